// ### core/gmp_map.svh
`ifndef GMP_MAP_SVH
`define GMP_MAP_SVH

// ----------------------------------------
// Timing figures, in picoseconds
// ----------------------------------------
`define GMP_SYS_PERIOD_PS 25000
`define GMP_T_125M_PS 8000
`define GMP_T_25M_PS 40000
`define GMP_T_2M5_PS 400000

// Least half period of a link clock made here, so the far end can sample it
`define GMP_MIN_HALF 8'h04

// ----------------------------------------
// Straps and widths
// ----------------------------------------
`define GMP_MODE_GMII_MII 4'h1
`define GMP_STRAP_WAIT 2'h3
`define GMP_FIFO_WIDTH 10
`define GMP_FIFO_DEPTH 16
`define GMP_NIB_ZERO 4'h0

`endif

// ### core/gmp_pkg.sv
`include "gmp_map.svh"

package gmp_pkg;

    // ----------------------------------------
    // Resolved link speed
    // ----------------------------------------
    typedef enum logic [1:0] {
        gmp_spd_10,
        gmp_spd_100,
        gmp_spd_1000
    } gmp_speed_t;

    // Link clock half period in system cycles, rounded down, never below the floor
    function automatic logic [7:0] half_cycles(input gmp_speed_t spd);
        int raw;
        case (spd)
            gmp_spd_10: raw = (`GMP_T_2M5_PS / 2) / `GMP_SYS_PERIOD_PS;
            gmp_spd_100: raw = (`GMP_T_25M_PS / 2) / `GMP_SYS_PERIOD_PS;
            default: raw = (`GMP_T_125M_PS / 2) / `GMP_SYS_PERIOD_PS;
        endcase
        if (raw < int'(`GMP_MIN_HALF)) begin
            raw = int'(`GMP_MIN_HALF);
        end
        return raw[7:0];
    endfunction : half_cycles

endpackage : gmp_pkg

// ### core/gmp_if.sv
`timescale 1ns/1ps

// Pin-level port between the transceiver and the MAC
interface gmp_if;
    logic tx_clk_mac; // Shared pin, MAC side drive
    logic tx_clk_mac_oe; // MAC drives the shared pin
    logic tx_clk_phy; // Shared pin, transceiver side drive
    logic tx_clk_phy_oe; // Transceiver drives the shared pin
    logic tx_clk_pin; // Resolved level of the shared pin
    logic tx_en;
    logic [7:0] txd;
    logic tx_er;
    logic rx_clk;
    logic rx_dv;
    logic [7:0] rxd;
    logic rx_er;
    logic crs;
    logic col;

    // Whoever enables wins, the transceiver if both do; nobody driving reads low
    assign tx_clk_pin = tx_clk_phy_oe ? tx_clk_phy : (tx_clk_mac_oe & tx_clk_mac);

    modport phy (
        input tx_clk_pin, tx_en, txd, tx_er,
        output tx_clk_phy, tx_clk_phy_oe, rx_clk, rx_dv, rxd, rx_er, crs, col
    );
    modport mac (
        input tx_clk_pin, rx_clk, rx_dv, rxd, rx_er, crs, col,
        output tx_clk_mac, tx_clk_mac_oe, tx_en, txd, tx_er
    );
endinterface : gmp_if

// ### core/gmp_fifo.sv
`timescale 1ns/1ps
`include "gmp_map.svh"
// ----------------------------------------
// Flip-flop FIFO with valid/ready on both sides
// ----------------------------------------
module gmp_fifo #(
    parameter int WIDTH = `GMP_FIFO_WIDTH,
    parameter int DEPTH = `GMP_FIFO_DEPTH
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH]; // Storage
    logic [AW-1:0] wr_ff; // Write index
    logic [AW-1:0] rd_ff; // Read index
    logic [AW:0] cnt_ff; // Words held
    logic push;
    logic pop;

    // Flags come straight from the count, so they never lie
    assign in_ready_o = (cnt_ff != FULL_CNT);
    assign out_valid_o = (cnt_ff != '0);
    assign out_data_o = mem_ff[rd_ff];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_ready_i & out_valid_o;

    // Storage write, no reset needed on data
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data_i;
        end
    end

    // Indices and count
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : gmp_fifo

// ### core/gmp_phy_end.sv
`timescale 1ns/1ps
`include "gmp_map.svh"
// What this block does
// - Gigabit: transmit clock and data come from MAC
// - Nibble mode uses sixteen port signals
// - Serves 10 and 100 Mbps, either duplex
// - Transmit and receive paths run independently
// - Nibble mode moves four bits per clock
// - Nibble mode: device makes transmit clock
// - Nibble mode: device outputs receive clock
// - MAC changes transmit signals on transmit clock
// - Receive signals change only on receive clock
// - Carrier and collision asynchronous; MAC synchronises them
// - Strap 0001 selects combined byte/nibble mode
// - Strap high enables reference output, toggling every system cycle (20 MHz)
// - Shared transmit clock pin direction follows speed
// - Gigabit: sample transmit signals on MAC clock rise
// - Gigabit: MAC samples receive signals on rise
// - Gigabit mode moves a byte per clock
module gmp_phy_end (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input gmp_pkg::gmp_speed_t speed_i, // Resolved link speed
    input wire logic full_duplex_i, // Resolved duplex
    input wire logic [3:0] mode_strap_i, // Interface mode strap
    input wire logic ref_clock_out_enable_strap_i, // Reference clock strap
    input wire logic [7:0] rx_data_i, // Byte from the line side
    input wire logic rx_err_i, // Byte carries a line error
    input wire logic rx_last_i, // Last byte of the frame
    input wire logic rx_valid_i,
    output logic rx_ready_o,
    output logic [7:0] tx_data_o, // Byte taken from the MAC
    output logic tx_err_o,
    output logic tx_valid_o,
    output logic tx_end_o, // Transmit enable fell
    output logic port_active_o, // Strap chose this port mode
    output logic ref_clock_125_out_o,
    gmp_if.phy link
);
    // ----------------------------------------
    // Pin synchronisers and straps
    // ----------------------------------------
    logic [15:0] s1_ff; // First stage, read only by the second
    logic [15:0] s2_ff; // Second stage
    logic clk_prev_ff; // Previous synced transmit clock
    logic [1:0] strap_cnt_ff; // Wait for straps to pass the synchroniser
    logic active_ff; // Combined mode selected
    logic refen_ff; // Reference output enabled
    gmp_pkg::gmp_speed_t spd_ff; // Speed in use
    logic gig;
    logic mii;
    logic gtx_rise;

    // Straps share the synchroniser with the transmit pins
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_ff <= '0;
            s2_ff <= '0;
            clk_prev_ff <= 1'b0;
        end else begin
            s1_ff <= {mode_strap_i, ref_clock_out_enable_strap_i, link.tx_clk_pin,
                      link.tx_en, link.tx_er, link.txd};
            s2_ff <= s1_ff;
            clk_prev_ff <= s2_ff[10];
        end
    end

    // Straps caught once, some cycles after reset release
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            strap_cnt_ff <= '0;
            active_ff <= 1'b0;
            refen_ff <= 1'b0;
        end else if (strap_cnt_ff != `GMP_STRAP_WAIT) begin
            strap_cnt_ff <= strap_cnt_ff + 1'b1;
            if (strap_cnt_ff == `GMP_STRAP_WAIT - 1'b1) begin
                active_ff <= (s2_ff[15:12] == `GMP_MODE_GMII_MII);
                refen_ff <= s2_ff[11];
            end
        end
    end

    // Speed tracked every cycle; change restarts framing below
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            spd_ff <= gmp_pkg::gmp_spd_10;
        end else begin
            spd_ff <= speed_i;
        end
    end

    assign gig = (spd_ff == gmp_pkg::gmp_spd_1000);
    assign mii = ~gig;
    assign gtx_rise = s2_ff[10] & ~clk_prev_ff;

    // ----------------------------------------
    // Link clock divider
    // ----------------------------------------
    logic [7:0] div_ff; // Cycles into this half period
    logic lclk_ff; // Link clock made here
    logic lrise_ff; // Pulse with a rising link clock
    logic lfall_ff; // Pulse with a falling link clock
    logic restart;

    assign restart = (speed_i != spd_ff) | ~active_ff;

    // One divider serves both clocks; a trade of skew freedom for area
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_ff <= '0;
            lclk_ff <= 1'b0;
            lrise_ff <= 1'b0;
            lfall_ff <= 1'b0;
        end else if (restart) begin
            div_ff <= '0;
            lclk_ff <= 1'b0;
            lrise_ff <= 1'b0;
            lfall_ff <= 1'b0;
        end else if (div_ff == gmp_pkg::half_cycles(spd_ff) - 1'b1) begin
            div_ff <= '0;
            lclk_ff <= ~lclk_ff;
            lrise_ff <= ~lclk_ff;
            lfall_ff <= lclk_ff;
        end else begin
            div_ff <= div_ff + 1'b1;
            lrise_ff <= 1'b0;
            lfall_ff <= 1'b0;
        end
    end

    // Shared pin: driven out only in nibble mode
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            link.tx_clk_phy <= 1'b0;
            link.tx_clk_phy_oe <= 1'b0;
            link.rx_clk <= 1'b0;
        end else begin
            link.tx_clk_phy <= lclk_ff;
            link.tx_clk_phy_oe <= active_ff & mii;
            link.rx_clk <= lclk_ff & active_ff;
        end
    end

    // ----------------------------------------
    // Transmit path, pins to user side
    // ----------------------------------------
    logic tx_smp;
    logic tx_was_en_ff; // Enable seen at last sample
    logic tx_hi_ff; // Low nibble held, high one next
    logic [3:0] tx_lo_ff; // Held low nibble
    logic tx_lo_er_ff; // Error seen with low nibble

    // MAC changes data on its own; we only look at sample points
    assign tx_smp = active_ff & (gig ? gtx_rise : lrise_ff);

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_was_en_ff <= 1'b0;
            tx_hi_ff <= 1'b0;
            tx_lo_ff <= '0;
            tx_lo_er_ff <= 1'b0;
            tx_data_o <= '0;
            tx_err_o <= 1'b0;
            tx_valid_o <= 1'b0;
            tx_end_o <= 1'b0;
        end else begin
            tx_valid_o <= 1'b0;
            tx_end_o <= 1'b0;
            if (restart) begin
                tx_hi_ff <= 1'b0;
                tx_was_en_ff <= 1'b0;
            end else if (tx_smp) begin
                tx_was_en_ff <= s2_ff[9];
                if (s2_ff[9]) begin
                    if (gig) begin
                        tx_data_o <= s2_ff[7:0];
                        tx_err_o <= s2_ff[8];
                        tx_valid_o <= 1'b1;
                    end else if (!tx_hi_ff) begin
                        tx_lo_ff <= s2_ff[3:0];
                        tx_lo_er_ff <= s2_ff[8];
                        tx_hi_ff <= 1'b1;
                    end else begin
                        tx_data_o <= {s2_ff[3:0], tx_lo_ff};
                        tx_err_o <= s2_ff[8] | tx_lo_er_ff;
                        tx_valid_o <= 1'b1;
                        tx_hi_ff <= 1'b0;
                    end
                end else begin
                    tx_hi_ff <= 1'b0; // Odd nibble at frame end is dropped
                    tx_end_o <= tx_was_en_ff;
                end
            end
        end
    end

    // ----------------------------------------
    // Receive path, FIFO to pins
    // ----------------------------------------
    logic [9:0] fifo_q; // {err, last, data}
    logic fifo_valid;
    logic fifo_ready;
    logic fifo_in_ready;
    logic rx_hi_ff; // High nibble still to send
    logic [3:0] rx_hi_nib_ff;
    logic rx_hi_er_ff;
    logic rx_gap_ff; // Force one idle slot after a frame

    gmp_fifo #(
        .WIDTH(`GMP_FIFO_WIDTH),
        .DEPTH(`GMP_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .in_data_i({rx_err_i, rx_last_i, rx_data_i}),
        .in_valid_i(rx_valid_i),
        .in_ready_o(fifo_in_ready),
        .out_data_o(fifo_q),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_ready)
    );

    // Pop only at a falling link clock when a new byte starts
    assign fifo_ready = active_ff & ~restart & lfall_ff & ~(mii & rx_hi_ff) & ~rx_gap_ff;

    // Ready registered; drain stalls between clock edges, so it fills
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_ready_o <= 1'b0;
        end else begin
            rx_ready_o <= fifo_in_ready;
        end
    end

    // Drive on the falling edge so the MAC samples stable data on the rise
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            link.rx_dv <= 1'b0;
            link.rxd <= '0;
            link.rx_er <= 1'b0;
            rx_hi_ff <= 1'b0;
            rx_hi_nib_ff <= '0;
            rx_hi_er_ff <= 1'b0;
            rx_gap_ff <= 1'b0;
        end else if (restart) begin
            link.rx_dv <= 1'b0;
            link.rxd <= '0;
            link.rx_er <= 1'b0;
            rx_hi_ff <= 1'b0;
            rx_gap_ff <= 1'b0;
        end else if (lfall_ff) begin
            if (mii && rx_hi_ff) begin
                link.rxd <= {`GMP_NIB_ZERO, rx_hi_nib_ff};
                link.rx_er <= rx_hi_er_ff;
                rx_hi_ff <= 1'b0;
            end else if (fifo_valid && !rx_gap_ff) begin
                link.rx_dv <= 1'b1;
                link.rxd <= gig ? fifo_q[7:0] : {`GMP_NIB_ZERO, fifo_q[3:0]};
                link.rx_er <= fifo_q[9];
                rx_hi_ff <= mii;
                rx_hi_nib_ff <= fifo_q[7:4];
                rx_hi_er_ff <= fifo_q[9];
                rx_gap_ff <= fifo_q[8];
            end else begin
                // Underrun or end of frame closes the frame
                link.rx_dv <= 1'b0;
                link.rxd <= '0;
                link.rx_er <= 1'b0;
                rx_gap_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Carrier, collision, reference clock
    // ----------------------------------------
    // Plain levels with no tie to either link clock
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            link.crs <= 1'b0;
            link.col <= 1'b0;
            ref_clock_125_out_o <= 1'b0;
            port_active_o <= 1'b0;
        end else begin
            link.crs <= active_ff & (s2_ff[9] | link.rx_dv);
            link.col <= active_ff & ~full_duplex_i & s2_ff[9] & link.rx_dv;
            ref_clock_125_out_o <= refen_ff & ~ref_clock_125_out_o;
            port_active_o <= active_ff;
        end
    end
endmodule : gmp_phy_end

// ### core/gmp_mac_end.sv
`timescale 1ns/1ps
`include "gmp_map.svh"
// ----------------------------------------
// MAC end of the byte/nibble port
// ----------------------------------------
module gmp_mac_end (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input gmp_pkg::gmp_speed_t speed_i, // Speed the MAC runs at
    input wire logic [7:0] tx_data_i,
    input wire logic tx_err_i,
    input wire logic tx_last_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    output logic [7:0] rx_data_o,
    output logic rx_err_o,
    output logic rx_valid_o,
    output logic rx_end_o, // Receive data valid fell
    output logic crs_o, // Synchronised carrier sense
    output logic col_o, // Synchronised collision
    gmp_if.mac link
);
    // ----------------------------------------
    // Synchronisers for everything the transceiver drives
    // ----------------------------------------
    logic [13:0] s1_ff; // First stage, read only by the second
    logic [13:0] s2_ff; // {txclk, rxclk, crs, col, dv, er, rxd}
    logic txc_prev_ff;
    logic rxc_prev_ff;
    gmp_pkg::gmp_speed_t spd_ff;
    logic gig;

    // Carrier and collision are asynchronous, so they go through here too
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_ff <= '0;
            s2_ff <= '0;
            txc_prev_ff <= 1'b0;
            rxc_prev_ff <= 1'b0;
            spd_ff <= gmp_pkg::gmp_spd_10;
        end else begin
            s1_ff <= {link.tx_clk_pin, link.rx_clk, link.crs, link.col,
                      link.rx_dv, link.rx_er, link.rxd};
            s2_ff <= s1_ff;
            txc_prev_ff <= s2_ff[13];
            rxc_prev_ff <= s2_ff[12];
            spd_ff <= speed_i;
        end
    end

    assign gig = (spd_ff == gmp_pkg::gmp_spd_1000);

    // ----------------------------------------
    // Gigabit transmit clock, made here
    // ----------------------------------------
    logic [7:0] div_ff;
    logic gclk_ff;
    logic gfall_ff; // Pulse as the made clock falls

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_ff <= '0;
            gclk_ff <= 1'b0;
            gfall_ff <= 1'b0;
        end else if (!gig) begin
            div_ff <= '0;
            gclk_ff <= 1'b0;
            gfall_ff <= 1'b0;
        end else if (div_ff == gmp_pkg::half_cycles(spd_ff) - 1'b1) begin
            div_ff <= '0;
            gclk_ff <= ~gclk_ff;
            gfall_ff <= gclk_ff;
        end else begin
            div_ff <= div_ff + 1'b1;
            gfall_ff <= 1'b0;
        end
    end

    // Pin enabled only at gigabit; transceiver drives it otherwise
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            link.tx_clk_mac <= 1'b0;
            link.tx_clk_mac_oe <= 1'b0;
        end else begin
            link.tx_clk_mac <= gclk_ff;
            link.tx_clk_mac_oe <= gig;
        end
    end

    // ----------------------------------------
    // Transmit: one byte held, sent whole or as two nibbles
    // ----------------------------------------
    logic hold_ff; // Byte waiting to go out
    logic [7:0] byte_ff;
    logic err_ff;
    logic last_ff;
    logic hi_ff; // High nibble goes next
    logic gap_ff; // One idle slot after a frame
    logic slot; // Moment to change the pins
    logic take;

    // Nibble mode changes right after the transceiver clock rises
    assign slot = gig ? gfall_ff : (s2_ff[13] & ~txc_prev_ff);
    assign take = tx_valid_i & tx_ready_o;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hold_ff <= 1'b0;
            byte_ff <= '0;
            err_ff <= 1'b0;
            last_ff <= 1'b0;
            hi_ff <= 1'b0;
            gap_ff <= 1'b0;
            tx_ready_o <= 1'b0;
            link.tx_en <= 1'b0;
            link.txd <= '0;
            link.tx_er <= 1'b0;
        end else begin
            tx_ready_o <= ~hold_ff & ~take;
            if (take) begin
                hold_ff <= 1'b1;
                byte_ff <= tx_data_i;
                err_ff <= tx_err_i;
                last_ff <= tx_last_i;
            end
            if (slot) begin
                if (hi_ff) begin
                    link.txd <= {`GMP_NIB_ZERO, byte_ff[7:4]};
                    hi_ff <= 1'b0;
                    hold_ff <= 1'b0;
                    gap_ff <= last_ff;
                end else if (hold_ff && !gap_ff) begin
                    link.tx_en <= 1'b1;
                    link.txd <= gig ? byte_ff : {`GMP_NIB_ZERO, byte_ff[3:0]};
                    link.tx_er <= err_ff;
                    hi_ff <= ~gig;
                    hold_ff <= ~gig;
                    gap_ff <= gig & last_ff;
                end else begin
                    link.tx_en <= 1'b0;
                    link.txd <= '0;
                    link.tx_er <= 1'b0;
                    gap_ff <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // Receive: sample on the rising receive clock
    // ----------------------------------------
    logic rx_rise;
    logic rhi_ff;
    logic [3:0] rlo_ff;
    logic rlo_er_ff;
    logic rwas_ff;

    assign rx_rise = s2_ff[12] & ~rxc_prev_ff;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rhi_ff <= 1'b0;
            rlo_ff <= '0;
            rlo_er_ff <= 1'b0;
            rwas_ff <= 1'b0;
            rx_data_o <= '0;
            rx_err_o <= 1'b0;
            rx_valid_o <= 1'b0;
            rx_end_o <= 1'b0;
            crs_o <= 1'b0;
            col_o <= 1'b0;
        end else begin
            rx_valid_o <= 1'b0;
            rx_end_o <= 1'b0;
            crs_o <= s2_ff[11];
            col_o <= s2_ff[10];
            if (rx_rise) begin
                rwas_ff <= s2_ff[9];
                if (!s2_ff[9]) begin
                    rhi_ff <= 1'b0;
                    rx_end_o <= rwas_ff;
                end else if (gig) begin
                    rx_data_o <= s2_ff[7:0];
                    rx_err_o <= s2_ff[8];
                    rx_valid_o <= 1'b1;
                end else if (!rhi_ff) begin
                    rlo_ff <= s2_ff[3:0];
                    rlo_er_ff <= s2_ff[8];
                    rhi_ff <= 1'b1;
                end else begin
                    rx_data_o <= {s2_ff[3:0], rlo_ff};
                    rx_err_o <= s2_ff[8] | rlo_er_ff;
                    rx_valid_o <= 1'b1;
                    rhi_ff <= 1'b0;
                end
            end
        end
    end
endmodule : gmp_mac_end

// ### tb/gmp_link_chk.sv
`timescale 1ns/1ps
// --------------------------------
// Link pin checks
// --------------------------------
module gmp_link_chk (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic tx_clk_mac,
    input wire logic tx_clk_mac_oe,
    input wire logic tx_clk_phy_oe,
    input wire logic tx_clk_pin,
    input wire logic tx_en,
    input wire logic [7:0] txd,
    input wire logic rx_clk,
    input wire logic rx_dv,
    input wire logic [7:0] rxd,
    input wire logic crs,
    input wire logic col
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    // Never two drivers on the shared pin
    property p_oe; !(tx_clk_mac_oe && tx_clk_phy_oe); endproperty
    a_oe: assert property (p_oe) else $error("shared pin double driven");
    property p_rxn; tx_clk_phy_oe && rx_dv |-> rxd[7:4] == 4'h0; endproperty
    a_rxn: assert property (p_rxn) else $error("rx upper nibble set");
    property p_txn; tx_clk_phy_oe && tx_en |-> txd[7:4] == 4'h0; endproperty
    a_txn: assert property (p_txn) else $error("tx upper nibble set");
    // Receive valid moves only with the falling link clock
    property p_rxs; $changed(rx_dv) |-> $fell(rx_clk); endproperty
    a_rxs: assert property (p_rxs) else $error("rx valid off clock");
    // Gigabit: MAC changes at its own fall, keeps setup to the rise
    property p_gtx; tx_clk_mac_oe && $changed(tx_en) |-> $fell(tx_clk_mac); endproperty
    a_gtx: assert property (p_gtx) else $error("tx enable off clock");
    property p_crs; $rose(rx_dv) |-> ##[0:4] crs; endproperty
    a_crs: assert property (p_crs) else $error("carrier late");
    property p_col; col |-> crs; endproperty
    a_col: assert property (p_col) else $error("collision without carrier");
    // Half period floor of 4 keeps clocks sampleable
    property p_rxc; $rose(rx_clk) |-> rx_clk[*4]; endproperty
    a_rxc: assert property (p_rxc) else $error("rx clock too short");
    property p_txc; $rose(tx_clk_pin) && tx_clk_phy_oe |-> tx_clk_pin[*4]; endproperty
    a_txc: assert property (p_txc) else $error("tx clock too short");
endmodule : gmp_link_chk

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
    logic clk_sys_i, nrst_i, fdx, cen, p_rv, p_rl, p_rr, m_tv, m_tl, m_tr;
    logic p_tvo, p_act, p_ref, m_rvo, m_col, col_seen;
    logic [3:0] strap;
    logic [7:0] p_rd, m_td, p_td, m_rd;
    logic [7:0] p_q[$];
    logic [7:0] m_q[$];
    gmp_pkg::gmp_speed_t spd;
    int failures = 0;
    int n_tests = 0;
    gmp_if link ();
    gmp_phy_end u_gmp_phy_end (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .speed_i(spd),
        .full_duplex_i(fdx), .mode_strap_i(strap), .ref_clock_out_enable_strap_i(cen),
        .rx_data_i(p_rd), .rx_err_i(1'b0), .rx_last_i(p_rl), .rx_valid_i(p_rv),
        .rx_ready_o(p_rr), .tx_data_o(p_td), .tx_err_o(), .tx_valid_o(p_tvo), .tx_end_o(),
        .port_active_o(p_act), .ref_clock_125_out_o(p_ref), .link(link));
    gmp_mac_end u_gmp_mac_end (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .speed_i(spd),
        .tx_data_i(m_td), .tx_err_i(1'b0), .tx_last_i(m_tl), .tx_valid_i(m_tv),
        .tx_ready_o(m_tr), .rx_data_o(m_rd), .rx_err_o(), .rx_valid_o(m_rvo), .rx_end_o(),
        .crs_o(), .col_o(m_col), .link(link));
    gmp_link_chk u_gmp_link_chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .tx_clk_mac(link.tx_clk_mac), .tx_clk_mac_oe(link.tx_clk_mac_oe),
        .tx_clk_phy_oe(link.tx_clk_phy_oe), .tx_clk_pin(link.tx_clk_pin), .tx_en(link.tx_en),
        .txd(link.txd), .rx_clk(link.rx_clk), .rx_dv(link.rx_dv), .rxd(link.rxd),
        .crs(link.crs), .col(link.col));
    // Clock, 25 ns
    initial begin
        clk_sys_i = 0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    // Collect what each end hands up
    always @(posedge clk_sys_i) begin
        if (p_tvo === 1'b1) p_q.push_back(p_td);
        if (m_rvo === 1'b1) m_q.push_back(m_rd);
        if (m_col === 1'b1) col_seen <= 1'b1;
    end
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Straps must sit still through reset
    task automatic start(gmp_pkg::gmp_speed_t s, logic d, logic [3:0] st, logic ce);
        nrst_i = 0; spd = s; fdx = d; strap = st; cen = ce; col_seen = 0;
        p_rv = 0; p_rl = 0; p_rd = 8'h00; m_tv = 0; m_tl = 0; m_td = 8'h00;
        repeat (10) @(posedge clk_sys_i);
        #2 nrst_i = 1;
        p_q.delete(); m_q.delete();
        repeat (6) @(posedge clk_sys_i);
        #2;
    endtask : start
    // Two-byte frame each way at once, then compare both ends
    task automatic t_frame(gmp_pkg::gmp_speed_t s, logic d, logic [7:0] a, logic [7:0] b);
        start(s, d, 4'h1, 1'b1);
        chk("port active", 8'h03, {6'h00, p_act, p_ref});
        fork
            begin
                m_tv = 1; m_td = a;
                do @(posedge clk_sys_i); while (m_tr !== 1'b1);
                #2 m_td = b; m_tl = 1;
                do @(posedge clk_sys_i); while (m_tr !== 1'b1);
                #2 m_tv = 0;
            end
            begin
                p_rv = 1; p_rd = b;
                do @(posedge clk_sys_i); while (p_rr !== 1'b1);
                #2 p_rd = a; p_rl = 1;
                do @(posedge clk_sys_i); while (p_rr !== 1'b1);
                #2 p_rv = 0;
            end
        join
        repeat (400) @(posedge clk_sys_i);
        #2;
        chk("tx count", 8'h02, 8'(p_q.size()));
        chk("rx count", 8'h02, 8'(m_q.size()));
        if (p_q.size() == 2 && m_q.size() == 2) begin
            chk("tx second", b, p_q[1]);
            chk("tx first", a, p_q[0]);
            chk("rx first", b, m_q[0]);
            chk("rx second", a, m_q[1]);
        end
        chk("collision", {7'h00, !d}, {7'h00, col_seen});
    endtask : t_frame
    // Wrong mode strap, reference strap low: port stays dark, no reference clock
    task automatic t_strap;
        logic seen;
        start(gmp_pkg::gmp_spd_100, 1'b1, 4'h0, 1'b0);
        seen = 0;
        repeat (40) @(posedge clk_sys_i) seen = seen | p_ref | link.tx_clk_pin;
        chk("idle port", 8'h00, {6'h00, p_act, seen});
    endtask : t_strap
    task automatic end_of_test;
        if (failures == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    initial begin
        #200us;
        failures++;
        end_of_test;
    end
    initial begin
        t_frame(gmp_pkg::gmp_spd_1000, 1'b1, 8'ha5, 8'h3c);
        t_frame(gmp_pkg::gmp_spd_100, 1'b1, 8'h5a, 8'hc3);
        t_frame(gmp_pkg::gmp_spd_10, 1'b0, 8'h0f, 8'hf0);
        t_strap;
        end_of_test;
    end
endmodule : tb
